// ---- design/cmp_pair_ctrl.sv ----
// design: control, edge detection and window logic of a paired analog comparator
// Functional notes
// - result high only when plus exceeds minus
// - edge field: any, reserved, falling, rising
// - event emitted on selected edge regardless of irq
// - priority field enables irq and sets level
// - hysteresis field forwarded to analog core
// - lowest control bit switches comparator on/off
// - enabled result continuously updated and readable
// - plus select picks pins zero to seven
// - bandgap and 64-level supply scaler inputs offered
// - both comparators identical with separate registers
// - window mode reports position against range
// - reserved bits read zero, software writes zero
// - comparator state drivable onto a port pin
// - minus select maps pins, bandgap and scaler
// - window condition: above, inside, below, outside
// - flags clear on vector ack or write-one
// - pin drive zero to pin seven, one to six
`timescale 1ns/1ps

module cmp_pair_ctrl
  import cmp_pair_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // analog cores
  input wire logic [1:0] cmp_raw_i,
  output analog_cfg_t [1:0] analog_cfg_o,
  output logic [5:0] scaler_level_o,
  // event routing and interrupt controller
  output logic [2:0] event_o,
  output logic [2:0][1:0] irq_level_o,
  input wire logic [2:0] irq_ack_i,
  // port pins 7 (comparator zero) and 6 (comparator one)
  output logic pin_drive_zero_o,
  output logic pin_drive_zero_oe_o,
  output logic pin_drive_one_o,
  output logic pin_drive_one_oe_o
);

  state_t s_r;
  state_t s_nxt;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic win_hit(input logic [1:0] cond, input logic [1:0] st);
    logic hit;
    hit = 1'b0;
    unique case (cond)
      WIN_ABOVE: hit = (st == WIN_ABOVE);
      WIN_INSIDE: hit = (st == WIN_INSIDE);
      WIN_BELOW: hit = (st == WIN_BELOW);
      WIN_OUTSIDE: hit = (st != WIN_INSIDE);
    endcase
    return hit;
  endfunction

  function automatic logic [7:0] read_reg(input state_t s, input logic [2:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      IDX_CMP0_CTRL: v = s.ctrl[0];
      IDX_CMP1_CTRL: v = s.ctrl[1];
      IDX_CMP0_MUX: v = s.mux[0];
      IDX_CMP1_MUX: v = s.mux[1];
      IDX_PIN_DRIVE: v = {6'h00, s.pin_en};
      IDX_SCALER: v = {2'h0, s.scale};
      IDX_WINDOW: v = {3'h0, s.win};
      IDX_STATUS: v = {s.wstate, s.res, 1'b0, s.flags};
    endcase
    return v;
  endfunction

  logic [2:0] aw_idx;
  logic [2:0] ar_idx;
  logic aw_ok;
  logic ar_ok;
  logic do_write;
  logic [2:0] flag_set;
  logic [2:0] flag_wclr;
  logic [1:0] new_wstate;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    aw_idx = s_r.aw_addr[IDX_LSB +: 3];
    aw_ok = (s_r.aw_addr[ADDR_W-1:IDX_LSB+3] == '0) && (s_r.aw_addr[1:0] == 2'h0);
    ar_idx = s_axi_araddr_i[IDX_LSB +: 3];
    ar_ok = (s_axi_araddr_i[ADDR_W-1:IDX_LSB+3] == '0) && (s_axi_araddr_i[1:0] == 2'h0);
    do_write = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    flag_set = 3'h0;
    flag_wclr = 3'h0;

    // write channel: address and data accepted in either order
    if (s_axi_awvalid_i && s_r.aw_rdy) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_r.w_rdy) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = s_axi_wdata_i[7:0];
      s_nxt.w_strb0 = s_axi_wstrb_i[0];
    end
    if (do_write) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = aw_ok ? RESP_OKAY : RESP_SLVERR;
      // data sits in byte lane 0; reserved bits are dropped so they read zero
      if (aw_ok && s_r.w_strb0) begin
        unique case (aw_idx)
          IDX_CMP0_CTRL: s_nxt.ctrl[0] = s_r.w_data & CTRL_MASK;
          IDX_CMP1_CTRL: s_nxt.ctrl[1] = s_r.w_data & CTRL_MASK;
          IDX_CMP0_MUX: s_nxt.mux[0] = s_r.w_data & MUX_MASK;
          IDX_CMP1_MUX: s_nxt.mux[1] = s_r.w_data & MUX_MASK;
          IDX_PIN_DRIVE: s_nxt.pin_en = s_r.w_data[1:0];
          IDX_SCALER: s_nxt.scale = s_r.w_data[5:0];
          IDX_WINDOW: s_nxt.win = s_r.w_data[4:0];
          IDX_STATUS: flag_wclr = s_r.w_data[STAT_FLAG_LSB +: 3];
        endcase
      end
    end
    if (s_r.bvalid && s_axi_bready_i) begin
      s_nxt.bvalid = 1'b0;
    end

    // read channel: one cycle from address to data
    if (s_axi_arvalid_i && s_r.ar_rdy) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = ar_ok ? read_reg(s_r, ar_idx) : 8'h00;
      s_nxt.rresp = ar_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready_i) begin
      s_nxt.rvalid = 1'b0;
    end

    // synchroniser; the first stage feeds only the second
    // a core that is off drives no valid level; gating it here keeps stale
    // samples from raising false edges when the core is switched back on
    s_nxt.sync1 = cmp_raw_i
                  & {s_r.ctrl[1][CTRL_ENABLE_BIT], s_r.ctrl[0][CTRL_ENABLE_BIT]};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.res_prev = s_r.res;
    s_nxt.event_p = 3'h0;
    for (int n = 0; n < 2; n++) begin
      // a disabled comparator reads zero; only its drop to zero at switch-off can raise an edge
      s_nxt.res[n] = s_r.sync2[n] & s_r.ctrl[n][CTRL_ENABLE_BIT];
      unique case (s_r.ctrl[n][CTRL_EDGE_LSB +: 2])
        EDGE_ANY: flag_set[n] = s_r.res[n] ^ s_r.res_prev[n];
        EDGE_FALL: flag_set[n] = s_r.res_prev[n] & !s_r.res[n];
        EDGE_RISE: flag_set[n] = !s_r.res_prev[n] & s_r.res[n];
        default: flag_set[n] = 1'b0;
      endcase
    end

    // window: comparator zero against upper bound, comparator one against lower
    if (s_r.res[0]) begin
      new_wstate = WIN_ABOVE;
    end else if (s_r.res[1]) begin
      new_wstate = WIN_INSIDE;
    end else begin
      new_wstate = WIN_BELOW;
    end
    if (s_r.win[WIN_EN_BIT]) begin
      s_nxt.wstate = new_wstate;
      flag_set[2] = (new_wstate != s_r.wstate)
                    && win_hit(s_r.win[WIN_COND_LSB +: 2], new_wstate);
    end else begin
      s_nxt.wstate = WIN_ABOVE;
    end

    // events fire whatever the irq setting; flag set wins over any clear
    s_nxt.event_p = flag_set;
    s_nxt.flags = (s_r.flags & ~(flag_wclr | irq_ack_i)) | flag_set;
    for (int n = 0; n < 2; n++) begin
      s_nxt.irq[n] = s_nxt.flags[n] ? s_r.ctrl[n][CTRL_PRIO_LSB +: 2] : 2'h0;
    end
    s_nxt.irq[2] = s_nxt.flags[2] ? s_r.win[WIN_LVL_LSB +: 2] : 2'h0;
    s_nxt.pin_val = s_r.res;

    // ready outputs come from flops fed from the next holding state, so they track it with no lag
    s_nxt.aw_rdy = !s_nxt.aw_held;
    s_nxt.w_rdy = !s_nxt.w_held;
    s_nxt.ar_rdy = !s_nxt.rvalid;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign s_axi_awready_o = s_r.aw_rdy;
  assign s_axi_wready_o = s_r.w_rdy;
  assign s_axi_bvalid_o = s_r.bvalid;
  assign s_axi_bresp_o = s_r.bresp;
  assign s_axi_arready_o = s_r.ar_rdy;
  assign s_axi_rvalid_o = s_r.rvalid;
  assign s_axi_rdata_o = {24'h000000, s_r.rdata};
  assign s_axi_rresp_o = s_r.rresp;

  generate
    for (genvar n = 0; n < 2; n++) begin : g_cfg
      assign analog_cfg_o[n].enable = s_r.ctrl[n][CTRL_ENABLE_BIT];
      assign analog_cfg_o[n].hysteresis_select = s_r.ctrl[n][CTRL_HYS_LSB +: 2];
      assign analog_cfg_o[n].plus_input_select = s_r.mux[n][MUX_PLUS_LSB +: 3];
      assign analog_cfg_o[n].minus_input_select = s_r.mux[n][MUX_MINUS_LSB +: 3];
    end
  endgenerate
  assign scaler_level_o = s_r.scale;
  assign event_o = s_r.event_p;
  assign irq_level_o = s_r.irq;
  assign pin_drive_zero_o = s_r.pin_val[0];
  assign pin_drive_zero_oe_o = s_r.pin_en[0];
  assign pin_drive_one_o = s_r.pin_val[1];
  assign pin_drive_one_oe_o = s_r.pin_en[1];

endmodule

// ---- design/cmp_pair_pkg.sv ----
// package: register map, field layout and carrier types of the comparator pair control
package cmp_pair_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [2:0] IDX_CMP0_CTRL = 3'h0;
  localparam logic [2:0] IDX_CMP1_CTRL = 3'h1;
  localparam logic [2:0] IDX_CMP0_MUX = 3'h2;
  localparam logic [2:0] IDX_CMP1_MUX = 3'h3;
  localparam logic [2:0] IDX_PIN_DRIVE = 3'h4;
  localparam logic [2:0] IDX_SCALER = 3'h5;
  localparam logic [2:0] IDX_WINDOW = 3'h6;
  localparam logic [2:0] IDX_STATUS = 3'h7;
  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;

  // ----------------------------------------------------------------------
  // field positions and writable masks
  // ----------------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_HYS_LSB = 1;
  localparam int CTRL_PRIO_LSB = 4;
  localparam int CTRL_EDGE_LSB = 6;
  localparam logic [7:0] CTRL_MASK = 8'hf7;
  localparam int MUX_MINUS_LSB = 0;
  localparam int MUX_PLUS_LSB = 3;
  localparam logic [7:0] MUX_MASK = 8'h3f;
  localparam int WIN_LVL_LSB = 0;
  localparam int WIN_COND_LSB = 2;
  localparam int WIN_EN_BIT = 4;
  localparam int STAT_FLAG_LSB = 0;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_WSTATE_LSB = 6;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // ----------------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] EDGE_ANY = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h3;
  localparam logic [1:0] WIN_ABOVE = 2'h0;
  localparam logic [1:0] WIN_INSIDE = 2'h1;
  localparam logic [1:0] WIN_BELOW = 2'h2;
  localparam logic [1:0] WIN_OUTSIDE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic [1:0] hysteresis_select;
    logic [2:0] plus_input_select;
    logic [2:0] minus_input_select;
  } analog_cfg_t;

  typedef struct packed {
    logic [1:0][7:0] ctrl;
    logic [1:0][7:0] mux;
    logic [1:0] pin_en;
    logic [5:0] scale;
    logic [4:0] win;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] res;
    logic [1:0] res_prev;
    logic [1:0] wstate;
    logic [2:0] flags;
    logic [2:0] event_p;
    logic [2:0][1:0] irq;
    logic [1:0] pin_val;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
  } state_t;

endpackage

// ---- bench/cmp_pair_ctrl_properties.sv ----
// checker: port properties of the comparator pair control
`timescale 1ns/1ps
module cmp_pair_ctrl_properties
  import cmp_pair_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid_i, s_axi_awready_o,
  input wire logic s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] cmp_raw_i,
  input wire analog_cfg_t [1:0] analog_cfg_o,
  input wire logic [2:0] event_o,
  input wire logic [2:0][1:0] irq_level_o,
  input wire logic [2:0] irq_ack_i,
  input wire logic pin_drive_zero_o, pin_drive_one_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  pin_zero_a: assert property (
    (analog_cfg_o[0].enable && $stable(cmp_raw_i[0]))[*7] |-> pin_drive_zero_o == cmp_raw_i[0])
    else $error("pin zero does not follow its comparator");
  pin_one_a: assert property (
    (analog_cfg_o[1].enable && $stable(cmp_raw_i[1]))[*7] |-> pin_drive_one_o == cmp_raw_i[1])
    else $error("pin one does not follow its comparator");
  off_gives_zero_a: assert property (
    (!analog_cfg_o[0].enable)[*7] |-> !pin_drive_zero_o)
    else $error("disabled comparator shows a one");
  event_on_change_a: assert property (
    event_o[0] |-> pin_drive_zero_o != $past(pin_drive_zero_o))
    else $error("event without a result change");
  ack_clears_a: assert property (
    irq_ack_i[0] |=> irq_level_o[0] == 2'h0 || event_o[0])
    else $error("acknowledge left the request standing");
  read_upper_zero_a: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  write_answer_a: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |=> ##1 s_axi_bvalid_o)
    else $error("write response late");
  read_answer_a: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read response late");
endmodule
bind cmp_pair_ctrl cmp_pair_ctrl_properties cmp_pair_ctrl_properties_inst (.*);

// ---- bench/cmp_core_model.sv ----
// partner: behavioural comparator cores with their input selection
`timescale 1ns/1ps
module cmp_core_model
  import cmp_pair_pkg::*;
#(
  parameter logic [7:0] BANDGAP_MV = 8'h4d
)(
  input wire logic clk_i,
  input wire analog_cfg_t [1:0] cfg_i,
  input wire logic [7:0][7:0] pin_mv_i,
  input wire logic [5:0] scale_i,
  output logic [1:0] raw_o
);
  logic idle_r = 1'b0;
  logic [1:0][7:0] plus_v, minus_v;
  // a core that is off gives no valid level, so it toggles
  always @(posedge clk_i) idle_r <= ~idle_r;
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      plus_v[n] = pin_mv_i[cfg_i[n].plus_input_select];
      case (cfg_i[n].minus_input_select)
        3'h0: minus_v[n] = pin_mv_i[0];
        3'h1: minus_v[n] = pin_mv_i[1];
        3'h2: minus_v[n] = pin_mv_i[3];
        3'h3: minus_v[n] = pin_mv_i[5];
        3'h4: minus_v[n] = pin_mv_i[7];
        3'h6: minus_v[n] = BANDGAP_MV;
        3'h7: minus_v[n] = 8'((16'(scale_i) + 16'h1) * 16'hff / 16'h40);
        default: minus_v[n] = 8'hff;
      endcase
      raw_o[n] = cfg_i[n].enable ? plus_v[n] > minus_v[n] : idle_r;
    end
  end
endmodule

// ---- bench/analog_comparator_pair_control_bench.sv ----
// bench: registers, edges, pins and window of the comparator pair control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end
module analog_comparator_pair_control_bench;
  import cmp_pair_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0, irq_ack_i = 3'h0;
  logic [3:0] s_axi_wstrb_i = 4'h1;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, cmp_raw_i;
  analog_cfg_t [1:0] analog_cfg_o;
  logic [5:0] scaler_level_o;
  logic [2:0] event_o;
  logic [2:0][1:0] irq_level_o;
  logic pin_drive_zero_o, pin_drive_zero_oe_o, pin_drive_one_o, pin_drive_one_oe_o;
  logic [7:0][7:0] pin_mv = '0;
  logic [1:0] modes [4] = '{EDGE_ANY, EDGE_FALL, EDGE_RISE, 2'h1};
  int want [4] = '{4, 2, 2, 0};
  int n_errors = 0, check_count = 0, cyc = 0, base = 0;
  int ev_cnt [3] = '{0, 0, 0};
  logic [9:0] expq [$];
  cmp_pair_ctrl cmp_pair_ctrl_inst (.*);
  cmp_core_model cmp_core_model_inst (.clk_i(clk_sys_i), .cfg_i(analog_cfg_o),
    .pin_mv_i(pin_mv), .scale_i(scaler_level_o), .raw_o(cmp_raw_i));
  always #5 clk_sys_i = ~clk_sys_i;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // the whole run needs some 430 cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // monitor: each answer takes the oldest note
  always @(posedge clk_sys_i) begin
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      `CHK("rdata", expq[0], {s_axi_rresp_o, s_axi_rdata_o[7:0]})
      void'(expq.pop_front());
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      `CHK("bresp", expq[0][9:8], s_axi_bresp_o)
      void'(expq.pop_front());
    end
    for (int k = 0; k < 3; k++) ev_cnt[k] += int'(event_o[k]);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk_sys_i);
    expq.push_back({r, 8'h00});
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [9:0] e);
    @(posedge clk_sys_i);
    expq.push_back(e);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge clk_sys_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clk_sys_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'h5d37f7c5));
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 10'h000);
    rd(8'h20, {RESP_SLVERR, 8'h00});
    wr(8'h21, 8'hff, RESP_SLVERR);
    $display("reset test done");
    for (int c = 0; c < 2; c++) begin
      wr(8'(4 * c), 8'hff, RESP_OKAY);
      wr(8'(8 + 4 * c), 8'hff, RESP_OKAY);
      rd(8'(4 * c), {RESP_OKAY, CTRL_MASK});
      rd(8'(8 + 4 * c), {RESP_OKAY, MUX_MASK});
      `CHK("cfg", 9'h1ff, analog_cfg_o[c])
      wr(8'(4 * c), 8'h00, RESP_OKAY);
    end
    repeat (8) @(posedge clk_sys_i);
    wr(8'h1c, 8'h07, RESP_OKAY);
    $display("register test done");
    pin_mv[1] <= 8'h64;
    wr(8'h08, 8'h01, RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, {modes[m], 2'h1, 4'h1}, RESP_OKAY);
      base = ev_cnt[0];
      for (int k = 0; k < 4; k++) begin
        pin_mv[0] <= k[0] ? 8'h32 : 8'h96;
        repeat (9) @(posedge clk_sys_i);
      end
      `CHK("events", want[m], ev_cnt[0] - base)
      `CHK("irq", want[m] > 0 ? 2'h1 : 2'h0, irq_level_o[0])
      if (m[0]) begin
        irq_ack_i <= 3'h1;
        @(posedge clk_sys_i);
        irq_ack_i <= 3'h0;
      end else wr(8'h1c, 8'h01, RESP_OKAY);
      repeat (2) @(posedge clk_sys_i);
      `CHK("irq clear", 2'h0, irq_level_o[0])
    end
    $display("edge test done");
    wr(8'h10, 8'h03, RESP_OKAY);
    repeat (2) @(posedge clk_sys_i);
    `CHK("pin oe", 2'h3, {pin_drive_one_oe_o, pin_drive_zero_oe_o})
    for (int i = 0; i < 6; i++) begin
      pin_mv[0] <= i == 0 ? 8'h64 : 8'($urandom_range(255));
      repeat (9) @(posedge clk_sys_i);
      rd(8'h1c, {RESP_OKAY, 3'h0, pin_mv[0] > pin_mv[1], 4'h0});
      `CHK("pin zero", pin_mv[0] > pin_mv[1], pin_drive_zero_o)
    end
    wr(8'h14, 8'hff, RESP_OKAY);
    rd(8'h14, {RESP_OKAY, 8'h3f});
    `CHK("scaler", 6'h3f, scaler_level_o)
    $display("pin test done");
    pin_mv[2] <= 8'h32;
    pin_mv[3] <= 8'hc8;
    pin_mv[5] <= 8'h64;
    wr(8'h08, 8'h12, RESP_OKAY);
    wr(8'h0c, 8'h13, RESP_OKAY);
    wr(8'h00, 8'h01, RESP_OKAY);
    wr(8'h04, 8'h01, RESP_OKAY);
    wr(8'h18, {3'h0, 1'b1, WIN_INSIDE, 2'h1}, RESP_OKAY);
    repeat (8) @(posedge clk_sys_i);
    base = ev_cnt[2];
    pin_mv[2] <= 8'h96;
    repeat (9) @(posedge clk_sys_i);
    `CHK("window events", 1, ev_cnt[2] - base)
    rd(8'h1c, {RESP_OKAY, 8'h66});
    `CHK("window irq", 2'h1, irq_level_o[2])
    wr(8'h1c, 8'h07, RESP_OKAY);
    wr(8'h18, {3'h0, 1'b1, WIN_OUTSIDE, 2'h1}, RESP_OKAY);
    base = ev_cnt[2];
    pin_mv[2] <= 8'hd0;
    repeat (9) @(posedge clk_sys_i);
    `CHK("outside events", 1, ev_cnt[2] - base)
    rd(8'h1c, {RESP_OKAY, 8'h35});
    $display("window test done");
    report_and_stop();
  end
endmodule
